// ---- iow_register_window.sv ----
// Host register window for seven 8-bit I/O ports plus logic-cell and system registers.
// Assumes host strobes and pin inputs are synchronous to mclk; one access per strobe cycle.
//
// How it works
// - Registers decode inside a 256-byte window placed by the user-supplied base byte.
// - Pin input registers return live pin levels, bit n is pin n.
// - Output latch registers hold written data and drive pins in software output mode.
// - Direction bit 0 makes the pin an input (reset), 1 an output.
// - Ports E, F, G mode bit 1 outputs a latched address bit instead of latch data.
// - Ports A, B, D, E, G drive bit selects push-pull (0) or open drain (1).
// - Ports C and F drive bit selects normal (0) or high slew rate (1).
// - Driver-enable status for A, B, C, F reads 1 where the pin driver is on.
// - Cell registers read cell outputs; writes load the cell flip-flops.
// - Block registers stop host writes loading the matching cell flip-flops.
// - Main flash sector lock reads back status; writes leave it alone.
// - Boot lock register reports security state and boot sector protection.
// - Space-select register places each memory area in program and/or data space.
// - Two read-only registers report memory sizes and boot memory type.
// - Page register feeds eight page bits to decode and resets to zero.
// - Scan port enable bit 0 turns the scan port on; other bits unused.
module iow_register_window #(
    parameter logic [7:0] MEM_SIZE_INFO_0 = 8'h00,
    parameter logic [7:0] MEM_SIZE_INFO_1 = 8'h00
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,

    // Host parallel bus
    input wire logic [15:0] host_addr,
    input wire logic [7:0] window_base,
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic [7:0] host_wdata,
    output logic [7:0] host_rdata,
    output logic register_window_select,

    // Port pins
    input wire iow_pkg::iow_port_bytes_t pin_in,
    output iow_pkg::iow_port_bytes_t pin_out,
    output iow_pkg::iow_port_bytes_t pin_oe,
    output iow_pkg::iow_port_bytes_t pin_fast_slew,

    // Latched address bits for ports E, F, G
    input wire iow_pkg::iow_three_bytes_t addr_out_bits,

    // Input logic cells A, B, D
    input wire iow_pkg::iow_three_bytes_t input_cells,

    // Output logic cells
    output logic [7:0] cell_out_a,
    output logic [7:0] cell_out_b,

    // Protection status
    input wire logic [7:0] main_lock_in,
    input wire logic [7:0] boot_lock_in,

    // System controls
    input wire logic [7:0] space_default,
    output logic scan_port_enable,
    output logic [7:0] page_bits,
    output logic [7:0] power_mgmt_config_0,
    output logic [7:0] power_mgmt_config_2,
    output logic [7:0] program_data_space_select
);
    import iow_pkg::*;

    // ==========================================================
    // Window decode
    // Low byte picks the register
    logic [7:0] offset;
    logic wr_hit;
    logic rd_hit;

    // High byte against the base places the window anywhere in host space
    assign register_window_select = (host_addr[15:8] == window_base);
    assign offset = host_addr[7:0];
    assign wr_hit = register_window_select && host_wr;
    assign rd_hit = register_window_select && host_rd;

    // Offset match, used by both the write and the read decode
    function automatic logic ofs_is(input logic [7:0] ofs, input logic [7:0] target);
        ofs_is = (ofs == target);
    endfunction : ofs_is

    // ==========================================================
    // Port configuration registers
    // One byte per port, index 0 is A
    iow_port_bytes_t out_latch_reg;
    iow_port_bytes_t dir_reg;
    iow_port_bytes_t drv_reg;
    iow_port_bytes_t mode_reg;

    // Output latches
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            out_latch_reg <= '0;
        end else if (wr_hit) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                if (ofs_is(offset, OUT_OFS[p])) begin
                    out_latch_reg[p] <= host_wdata;
                end
            end
        end
    end

    // Direction clears, so pins come up as inputs
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            dir_reg <= '0;
        end else if (wr_hit) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                if (ofs_is(offset, DIR_OFS[p])) begin
                    dir_reg[p] <= host_wdata;
                end
            end
        end
    end

    // Driver type clears to plain CMOS
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            drv_reg <= '0;
        end else if (wr_hit) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                if (ofs_is(offset, DRV_OFS[p])) begin
                    drv_reg[p] <= host_wdata;
                end
            end
        end
    end

    // Mode clears to software I/O
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            mode_reg <= '0;
        end else if (wr_hit) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                if (HAS_MODE[p] && ofs_is(offset, MODE_OFS[p])) begin
                    mode_reg[p] <= host_wdata;
                end
            end
        end
    end

    // ==========================================================
    // Pin drivers
    iow_port_bytes_t pin_value;
    iow_port_bytes_t pin_enable;
    iow_port_bytes_t addr_ext;

    // Address bits aligned to E, F, G; no negative port index
    assign addr_ext = {addr_out_bits, 32'h0000_0000};

    // Address mode forces the driver on
    // Source and enable per pin before the driver type is applied
    always_comb begin
        for (int p = 0; p < NUM_PORTS; p++) begin
            for (int b = 0; b < 8; b++) begin
                if (HAS_MODE[p] && mode_reg[p][b]) begin
                    pin_value[p][b] = addr_ext[p][b];
                    pin_enable[p][b] = 1'b1;
                end else begin
                    pin_value[p][b] = out_latch_reg[p][b];
                    pin_enable[p][b] = dir_reg[p][b];
                end
            end
        end
    end

    // Slew ports never go open drain
    // Registered pins; open drain only ever pulls low, so a one releases the pin
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pin_out <= '0;
            pin_oe <= '0;
            pin_fast_slew <= '0;
        end else begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                if (!SLEW_PORTS[p]) begin
                    pin_out[p] <= pin_value[p] & ~drv_reg[p];
                    pin_oe[p] <= pin_enable[p] & ~(drv_reg[p] & pin_value[p]);
                    pin_fast_slew[p] <= RESET_ZERO;
                end else begin
                    pin_out[p] <= pin_value[p];
                    pin_oe[p] <= pin_enable[p];
                    pin_fast_slew[p] <= drv_reg[p] & pin_enable[p];
                end
            end
        end
    end

    // ==========================================================
    // Output logic cells and their write blocks
    logic [7:0] cell_a_reg;
    logic [7:0] cell_b_reg;
    logic [7:0] block_a_reg;
    logic [7:0] block_b_reg;

    // A set block bit shields that cell
    // Block registers are plain storage
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            block_a_reg <= RESET_ZERO;
            block_b_reg <= RESET_ZERO;
        end else if (wr_hit) begin
            if (ofs_is(offset, OFS_BLOCK_A)) begin
                block_a_reg <= host_wdata;
            end
            if (ofs_is(offset, OFS_BLOCK_B)) begin
                block_b_reg <= host_wdata;
            end
        end
    end

    // Blocked bits keep their value; the rest take the written data
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cell_a_reg <= RESET_ZERO;
            cell_b_reg <= RESET_ZERO;
        end else if (wr_hit) begin
            if (ofs_is(offset, OFS_CELLS_A)) begin
                cell_a_reg <= (cell_a_reg & block_a_reg) | (host_wdata & ~block_a_reg);
            end
            if (ofs_is(offset, OFS_CELLS_B)) begin
                cell_b_reg <= (cell_b_reg & block_b_reg) | (host_wdata & ~block_b_reg);
            end
        end
    end

    // Cells are loaded only by the host here
    assign cell_out_a = cell_a_reg;
    assign cell_out_b = cell_b_reg;

    // ==========================================================
    // System registers
    // No side effects inside this block
    logic [7:0] page_reg;
    logic [7:0] pm0_reg;
    logic [7:0] pm2_reg;
    logic scan_en_reg;

    // Page bits for address decode
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            page_reg <= RESET_ZERO;
        end else if (wr_hit && ofs_is(offset, OFS_PAGE)) begin
            page_reg <= host_wdata;
        end
    end

    // Power control 0
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pm0_reg <= RESET_ZERO;
        end else if (wr_hit && ofs_is(offset, OFS_PM_CFG0)) begin
            pm0_reg <= host_wdata;
        end
    end

    // Power control 2
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pm2_reg <= RESET_ZERO;
        end else if (wr_hit && ofs_is(offset, OFS_PM_CFG2)) begin
            pm2_reg <= host_wdata;
        end
    end

    // Scan port enable, bit 0 only
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            scan_en_reg <= 1'b0;
        end else if (wr_hit && ofs_is(offset, OFS_SCAN_EN)) begin
            scan_en_reg <= host_wdata[0];
        end
    end

    // Straight from the flip-flops
    assign page_bits = page_reg;
    assign power_mgmt_config_0 = pm0_reg;
    assign power_mgmt_config_2 = pm2_reg;
    assign scan_port_enable = scan_en_reg;

    // ==========================================================
    // Program/data space select
    // A write in the first cycle is lost
    logic [7:0] space_reg;
    logic space_loaded_reg;

    // Reset clears all bits; the configured defaults of bits 1-4 are taken
    // on the first edge after release, since async reset may only load constants
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            space_reg <= RESET_ZERO;
            space_loaded_reg <= 1'b0;
        end else if (!space_loaded_reg) begin
            space_reg <= space_default & SPACE_STRAP_MASK;
            space_loaded_reg <= 1'b1;
        end else if (wr_hit && ofs_is(offset, OFS_SPACE_SEL)) begin
            space_reg <= host_wdata & SPACE_SEL_MASK;
        end
    end

    // Bits 5 and 6 always read zero
    assign program_data_space_select = space_reg;

    // ==========================================================
    // Read path
    logic [7:0] read_mux;
    logic [7:0] rdata_reg;

    // Read-only offsets have no write branch anywhere, so writes to them are dropped
    always_comb begin
        read_mux = RESET_ZERO;
        for (int p = 0; p < NUM_PORTS; p++) begin
            if (ofs_is(offset, IN_OFS[p])) begin
                read_mux = pin_in[p];
            end
            if (ofs_is(offset, OUT_OFS[p])) begin
                read_mux = out_latch_reg[p];
            end
            if (ofs_is(offset, DIR_OFS[p])) begin
                read_mux = dir_reg[p];
            end
            if (ofs_is(offset, DRV_OFS[p])) begin
                read_mux = drv_reg[p];
            end
            if (HAS_MODE[p] && ofs_is(offset, MODE_OFS[p])) begin
                read_mux = mode_reg[p];
            end
            if (HAS_OE_STAT[p] && ofs_is(offset, OE_OFS[p])) begin
                read_mux = pin_oe[p];
            end
        end
        // Non-port registers share no offset
        case (offset)
            OFS_IN_CELLS_A: read_mux = input_cells[0];
            OFS_IN_CELLS_B: read_mux = input_cells[1];
            OFS_IN_CELLS_D: read_mux = input_cells[2];
            OFS_CELLS_A: read_mux = cell_a_reg;
            OFS_CELLS_B: read_mux = cell_b_reg;
            OFS_BLOCK_A: read_mux = block_a_reg;
            OFS_BLOCK_B: read_mux = block_b_reg;
            OFS_PM_CFG0: read_mux = pm0_reg;
            OFS_PM_CFG2: read_mux = pm2_reg;
            OFS_MAIN_LOCK: read_mux = main_lock_in;
            OFS_BOOT_LOCK: read_mux = boot_lock_in & BOOT_LOCK_MASK;
            OFS_SCAN_EN: read_mux = {7'h00, scan_en_reg};
            OFS_PAGE: read_mux = page_reg;
            OFS_SPACE_SEL: read_mux = space_reg;
            OFS_MEM_INFO0: read_mux = MEM_SIZE_INFO_0;
            OFS_MEM_INFO1: read_mux = MEM_SIZE_INFO_1;
            default: read_mux = read_mux;
        endcase
    end

    // Registered for stable data, one cycle late
    // Read data is captured on the strobe and held until the next read
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_reg <= RESET_ZERO;
        end else if (rd_hit) begin
            rdata_reg <= read_mux;
        end
    end

    // Reads outside the window keep it
    assign host_rdata = rdata_reg;

endmodule : iow_register_window

// ---- iow_pkg.sv ----
// Constants for the host-visible I/O port register window.
// Assumes an 8-bit host bus with the window selected by the high address byte.
package iow_pkg;

    // ==========================================================
    // Sizes
    localparam int NUM_PORTS = 7;
    localparam int WINDOW_BYTES = 256;

    typedef logic [NUM_PORTS-1:0][7:0] iow_port_bytes_t;
    typedef logic [2:0][7:0] iow_three_bytes_t;

    // ==========================================================
    // Per-port offsets, index 0 is port A and index 6 is port G
    localparam iow_port_bytes_t IN_OFS =
        {8'h41, 8'h40, 8'h30, 8'h11, 8'h10, 8'h01, 8'h00};
    localparam iow_port_bytes_t OUT_OFS =
        {8'h45, 8'h44, 8'h34, 8'h15, 8'h14, 8'h05, 8'h04};
    localparam iow_port_bytes_t DIR_OFS =
        {8'h47, 8'h46, 8'h36, 8'h17, 8'h16, 8'h07, 8'h06};
    localparam iow_port_bytes_t DRV_OFS =
        {8'h49, 8'h48, 8'h38, 8'h19, 8'h18, 8'h09, 8'h08};
    // Only E, F and G have a mode register; other entries are never matched
    localparam iow_port_bytes_t MODE_OFS =
        {8'h43, 8'h42, 8'h32, 8'h00, 8'h00, 8'h00, 8'h00};
    localparam logic [NUM_PORTS-1:0] HAS_MODE = 7'h70;
    // Ports C and F select slew rate, the rest select open drain
    localparam logic [NUM_PORTS-1:0] SLEW_PORTS = 7'h24;
    // Driver-enable status exists for A, B, C and F
    localparam iow_port_bytes_t OE_OFS =
        {8'h00, 8'h4C, 8'h00, 8'h00, 8'h1C, 8'h0D, 8'h0C};
    localparam logic [NUM_PORTS-1:0] HAS_OE_STAT = 7'h27;
    // First port whose mode register exists (E)
    localparam int MODE_BASE = 4;

    // ==========================================================
    // Logic-cell and system register offsets
    localparam logic [7:0] OFS_IN_CELLS_A = 8'h0A;
    localparam logic [7:0] OFS_IN_CELLS_B = 8'h0B;
    localparam logic [7:0] OFS_IN_CELLS_D = 8'h1A;
    localparam logic [7:0] OFS_CELLS_A = 8'h20;
    localparam logic [7:0] OFS_CELLS_B = 8'h21;
    localparam logic [7:0] OFS_BLOCK_A = 8'h22;
    localparam logic [7:0] OFS_BLOCK_B = 8'h23;
    localparam logic [7:0] OFS_PM_CFG0 = 8'hB0;
    localparam logic [7:0] OFS_PM_CFG2 = 8'hB4;
    localparam logic [7:0] OFS_MAIN_LOCK = 8'hC0;
    localparam logic [7:0] OFS_BOOT_LOCK = 8'hC2;
    localparam logic [7:0] OFS_SCAN_EN = 8'hC7;
    localparam logic [7:0] OFS_PAGE = 8'hE0;
    localparam logic [7:0] OFS_SPACE_SEL = 8'hE2;
    localparam logic [7:0] OFS_MEM_INFO0 = 8'hF0;
    localparam logic [7:0] OFS_MEM_INFO1 = 8'hF1;

    // ==========================================================
    // Field masks and reset values
    localparam logic [7:0] BOOT_LOCK_MASK = 8'h8F;
    localparam logic [7:0] SCAN_EN_MASK = 8'h01;
    localparam logic [7:0] SPACE_SEL_MASK = 8'h9F;
    localparam logic [7:0] SPACE_STRAP_MASK = 8'h1E;
    localparam logic [7:0] RESET_ZERO = 8'h00;

endpackage : iow_pkg

// ---- iow_register_window_assertions.sv ----
// Checker for the register window, watching top-level ports only.
// Assumes the host strobes are synchronous to mclk and one access per strobe.
module iow_register_window_assertions #(
    parameter logic [7:0] MEM_SIZE_INFO_0 = 8'h00,
    parameter logic [7:0] MEM_SIZE_INFO_1 = 8'h00
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Host bus
    input wire logic [15:0] host_addr,
    input wire logic [7:0] window_base,
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic [7:0] host_wdata,
    input wire logic [7:0] host_rdata,
    input wire logic register_window_select,
    // Pins and status
    input wire iow_pkg::iow_port_bytes_t pin_in,
    input wire iow_pkg::iow_port_bytes_t pin_oe,
    input wire iow_pkg::iow_port_bytes_t pin_fast_slew,
    input wire logic [7:0] main_lock_in,
    input wire logic [7:0] boot_lock_in,
    input wire logic [7:0] page_bits,
    input wire logic scan_port_enable,
    input wire logic [7:0] program_data_space_select
);
    import iow_pkg::*;
    logic [7:0] ofs;
    logic rd_in;
    logic wr_in;
    // ==========================================================
    // Decoded access helpers
    assign ofs = host_addr[7:0];
    assign rd_in = host_rd && register_window_select;
    assign wr_in = host_wr && register_window_select;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    // ==========================================================
    // Properties
    win_select_a: assert property (register_window_select == (host_addr[15:8] == window_base))
        else $error("window select does not follow the base compare");
    rdata_hold_a: assert property (host_rd && !register_window_select |=> $stable(host_rdata))
        else $error("read outside the window changed read data");
    pin_read_a: assert property (rd_in && ofs == 8'h00 |=> host_rdata == $past(pin_in[0]))
        else $error("port A input read wrong");
    dir_input_a: assert property (wr_in && ofs == 8'h06 |-> ##2 (pin_oe[0] & ~$past(host_wdata, 2)) == 8'h00)
        else $error("port A input pin still driven");
    slew_only_a: assert property ((pin_fast_slew[0] | pin_fast_slew[1] | pin_fast_slew[3]
        | pin_fast_slew[4] | pin_fast_slew[6]) == 8'h00)
        else $error("slew set on a port without slew control");
    main_lock_a: assert property (rd_in && ofs == 8'hC0 |=> host_rdata == $past(main_lock_in))
        else $error("main lock read wrong");
    boot_lock_a: assert property (rd_in && ofs == 8'hC2 |=> host_rdata == ($past(boot_lock_in) & 8'h8F))
        else $error("boot lock read wrong");
    space_write_a: assert property (wr_in && ofs == 8'hE2 |=> program_data_space_select == ($past(host_wdata) & 8'h9F))
        else $error("space select not loaded");
    mem_info_a: assert property (rd_in && ofs == 8'hF1 |=> host_rdata == MEM_SIZE_INFO_1)
        else $error("memory info read wrong");
    page_load_a: assert property (wr_in && ofs == 8'hE0 |=> page_bits == $past(host_wdata))
        else $error("page bits not loaded");
    scan_load_a: assert property (wr_in && ofs == 8'hC7 |=> scan_port_enable == $past(host_wdata[0]))
        else $error("scan enable not loaded");
    hole_zero_a: assert property (rd_in && ofs == 8'h02 |=> host_rdata == 8'h00)
        else $error("undecoded read not zero");
    // ==========================================================
    // Scenario covers
    cover property (wr_in && ofs == 8'h20);
    cover property (rd_in && ofs == 8'h4C);
    cover property (host_wr && !register_window_select);
endmodule : iow_register_window_assertions

bind iow_register_window iow_register_window_assertions #(.MEM_SIZE_INFO_0(MEM_SIZE_INFO_0),
    .MEM_SIZE_INFO_1(MEM_SIZE_INFO_1)) u_chk (.mclk(mclk), .reset_n(reset_n), .host_addr(host_addr),
    .window_base(window_base), .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .register_window_select(register_window_select), .pin_in(pin_in),
    .pin_oe(pin_oe), .pin_fast_slew(pin_fast_slew), .main_lock_in(main_lock_in),
    .boot_lock_in(boot_lock_in), .page_bits(page_bits), .scan_port_enable(scan_port_enable),
    .program_data_space_select(program_data_space_select));

// ---- iow_host_model.sv ----
// Host bus model: one byte access per strobe, driven on falling edges.
// Assumes the window samples strobes on rising mclk; lines scramble when idle.
module iow_host_model (
    // Clock
    input wire logic mclk,
    // Host bus
    output logic [15:0] host_addr,
    output logic host_wr,
    output logic host_rd,
    output logic [7:0] host_wdata,
    input wire logic [7:0] host_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Bus idle at time zero
    initial begin
        host_addr = 16'h0000;
        host_wr = 1'b0;
        host_rd = 1'b0;
        host_wdata = 8'h00;
    end
    // Strobe held over one rising edge, then released lines are inverted
    task automatic access(logic [15:0] a, logic [7:0] d, logic w, output logic [7:0] q);
        @(negedge mclk);
        host_addr = a;
        host_wdata = d;
        host_wr = w;
        host_rd = !w;
        @(negedge mclk);
        q = host_rdata;
        host_wr = 1'b0;
        host_rd = 1'b0;
        host_wdata = ~d;
        host_addr = ~a;
    endtask : access
endmodule : iow_host_model

// ---- io_port_register_window_tb.sv ----
// Self-checking bench: random writes and full-window reads against an associative-array model.
// Assumes iow_host_model as bus master and the bound checker.
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin num_errors++; \
    $display("MISMATCH %0t: got %h exp %h", $time, a, b); end end
module io_port_register_window_tb;
    import iow_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] MI0 = 8'h5A;
    localparam logic [7:0] MI1 = 8'hC3;
    localparam int RW_SYS[8] = '{'h20, 'h21, 'h22, 'h23, 'hB0, 'hB4, 'hC7, 'hE0};
    logic mclk, reset_n, host_wr, host_rd, sel, scan_en;
    logic [15:0] host_addr;
    logic [7:0] base, hi, d, rv, host_wdata, host_rdata, ml, bl, sdef, ca, cb, pg, pm0, pm2, sp;
    iow_port_bytes_t pin_in, pin_out, pin_oe, pin_fs;
    iow_three_bytes_t aob, icl;
    int num_errors = 0;
    int cmp_count = 0;
    int mdl[int];
    // ==========================================================
    // Clock, design and host
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    iow_register_window #(.MEM_SIZE_INFO_0(MI0), .MEM_SIZE_INFO_1(MI1)) u_dut (.mclk(mclk),
        .reset_n(reset_n), .host_addr(host_addr), .window_base(base), .host_wr(host_wr),
        .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(host_rdata),
        .register_window_select(sel), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_fast_slew(pin_fs), .addr_out_bits(aob), .input_cells(icl), .cell_out_a(ca),
        .cell_out_b(cb), .main_lock_in(ml), .boot_lock_in(bl), .space_default(sdef),
        .scan_port_enable(scan_en), .page_bits(pg), .power_mgmt_config_0(pm0),
        .power_mgmt_config_2(pm2), .program_data_space_select(sp));
    iow_host_model u_host (.mclk(mclk), .host_addr(host_addr), .host_wr(host_wr),
        .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(host_rdata));
    // ==========================================================
    // Model: expected {enable, value} of one port
    function automatic logic [15:0] pexp(int p);
        logic [7:0] md, v, dv;
        md = HAS_MODE[p] ? 8'(mdl[MODE_OFS[p]]) : 8'h00;
        v = (md & (HAS_MODE[p] ? aob[p - MODE_BASE] : 8'h00)) | (~md & 8'(mdl[OUT_OFS[p]]));
        dv = SLEW_PORTS[p] ? 8'h00 : 8'(mdl[DRV_OFS[p]]);
        return {(md | 8'(mdl[DIR_OFS[p]])) & ~(dv & v), v & ~dv};
    endfunction : pexp
    // Expected read data; unknown offsets read zero
    function automatic logic [7:0] exp_rd(int o);
        logic [15:0] e;
        if (mdl.exists(o)) return 8'(mdl[o]);
        for (int p = 0; p < NUM_PORTS; p++) begin
            e = pexp(p);
            if (o == IN_OFS[p]) return pin_in[p];
            if (HAS_OE_STAT[p] && o == OE_OFS[p]) return e[15:8];
        end
        case (o)
            'h0A: return icl[0];
            'h0B: return icl[1];
            'h1A: return icl[2];
            'hC0: return ml;
            'hC2: return bl & BOOT_LOCK_MASK;
            'hF0: return MI0;
            'hF1: return MI1;
            default: return 8'h00;
        endcase
    endfunction : exp_rd
    // Writes land only on writable offsets; blocked cell bits keep old value
    function automatic void mdl_wr(int o, logic [7:0] dd);
        if (!mdl.exists(o)) return;
        if (o == 'h20 || o == 'h21) mdl[o] = (mdl[o] & mdl[o + 2]) | (dd & ~mdl[o + 2]);
        else if (o == 'hC7) mdl[o] = dd & SCAN_EN_MASK;
        else if (o == 'hE2) mdl[o] = dd & SPACE_SEL_MASK;
        else mdl[o] = dd;
    endfunction : mdl_wr
    // ==========================================================
    // Bench tasks
    task automatic do_reset();
        @(negedge mclk);
        reset_n = 1'b0;
        repeat (2) @(negedge mclk);
        `CHK(pin_oe, '0)
        reset_n = 1'b1;
        mdl.delete();
        for (int p = 0; p < NUM_PORTS; p++) begin
            mdl[OUT_OFS[p]] = 0;
            mdl[DIR_OFS[p]] = 0;
            mdl[DRV_OFS[p]] = 0;
            if (HAS_MODE[p]) mdl[MODE_OFS[p]] = 0;
        end
        foreach (RW_SYS[i]) mdl[RW_SYS[i]] = 0;
        mdl['hE2] = sdef & SPACE_STRAP_MASK;
        repeat (2) @(negedge mclk);
    endtask : do_reset
    task automatic chk_pins();
        logic [15:0] e;
        for (int p = 0; p < NUM_PORTS; p++) begin
            e = pexp(p);
            `CHK(pin_out[p], e[7:0])
            `CHK(pin_oe[p], e[15:8])
            `CHK(pin_fs[p], SLEW_PORTS[p] ? e[15:8] & 8'(mdl[DRV_OFS[p]]) : 8'h00)
        end
        `CHK({ca, cb}, {8'(mdl['h20]), 8'(mdl['h21])})
        `CHK({pg, sp, scan_en}, {8'(mdl['hE0]), 8'(mdl['hE2]), mdl['hC7][0]})
        `CHK({pm0, pm2}, {8'(mdl['hB0]), 8'(mdl['hB4])})
    endtask : chk_pins
    task automatic rd_chk(int o);
        u_host.access({base, 8'(o)}, 8'h00, 1'b0, rv);
        `CHK(rv, exp_rd(o))
    endtask : rd_chk
    task automatic test_done();
        $display("checks %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : test_done
    // ==========================================================
    // Main sequence: round 3 writes outside the window, round 4 resets
    initial begin
        reset_n = 1'b0;
        void'($urandom(32'hA7DF));
        base = 8'($urandom);
        {ml, bl, sdef} = 24'($urandom);
        pin_in = 56'({$urandom, $urandom});
        aob = 24'($urandom);
        icl = 24'($urandom);
        do_reset();
        foreach (mdl[o]) rd_chk(o);
        chk_pins();
        $display("test reset_values done");
        for (int r = 0; r < 6; r++) begin
            hi = (r == 3) ? ~base : base;
            for (int o = 0; o < WINDOW_BYTES; o++) begin
                d = 8'($urandom);
                u_host.access({hi, 8'(o)}, d, 1'b1, rv);
                if (r != 3) mdl_wr(o, d);
            end
            u_host.access({~base, 8'h04}, 8'h00, 1'b0, rv);
            pin_in = 56'({$urandom, $urandom});
            @(negedge mclk);
            chk_pins();
            for (int o = 0; o < WINDOW_BYTES; o++) rd_chk(o);
            if (r == 4) do_reset();
            $display("test round %0d done", r);
        end
        test_done();
    end
    // Watchdog well beyond the ~6200 cycles the rounds need
    initial begin
        repeat (30000) @(posedge mclk);
        num_errors++;
        $display("MISMATCH %0t: watchdog expired", $time);
        test_done();
    end
endmodule : io_port_register_window_tb
